// ---- tb/can_bus_model.sv ----
// behavioural bus and controller core beside the status block
module can_bus_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start_tx,
	input wire logic start_rx,
	output logic tx_busy,
	output logic rx_busy,
	output logic sof,
	output logic tick,
	output logic rx
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] div_r;
	logic [3:0] len_r;
	// bit sample every fourth clock
	assign tick = (div_r == 2'h3);
	// ten-bit frame; pin drops at the start, then changes only after a sample, idles recessive
	always_ff @(posedge clk) begin
		div_r <= rst_n ? div_r + 2'h1 : 2'h0;
		sof <= 1'b0;
		if (!rst_n) begin
			len_r <= 4'h0;
			tx_busy <= 1'b0;
			rx_busy <= 1'b0;
			rx <= 1'b1;
		end else if (start_tx || start_rx) begin
			tx_busy <= start_tx;
			rx_busy <= start_rx;
			sof <= 1'b1;
			len_r <= 4'hA;
			rx <= 1'b0;
		end else if (tick && len_r != 4'h0) begin
			len_r <= len_r - 4'h1;
			rx <= (len_r > 4'h1) ? len_r[0] : 1'b1;
			if (len_r == 4'h1) begin
				tx_busy <= 1'b0;
				rx_busy <= 1'b0;
			end
		end
	end
endmodule : can_bus_model

// ---- tb/can_master_status_flags_tb.sv ----
// self-checking bench for the master status flag block
module can_master_status_flags_tb
	import master_status_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
		num_errors++; $display("Error %s exp %0h got %0h", nm, e, g); end end
	logic mclk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, start_tx = 0, start_rx = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0] err_cond = 0;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, tx_b, rx_b, sof, tick;
	logic rx, sleep_ack, freeze_ack, status_irq, irq;
	int num_errors = 0, checks_done = 0;
	can_bus_model i_bus (.clk(mclk), .rst_n(rst_n), .start_tx(start_tx),
		.start_rx(start_rx), .tx_busy(tx_b), .rx_busy(rx_b), .sof(sof),
		.tick(tick), .rx(rx));
	can_master_status_flags i_dut (.MCLK(mclk), .RST_N(rst_n),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
		.ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
		.RVALID(rvalid), .RREADY(rready), .TX_BUSY(tx_b), .RX_BUSY(rx_b),
		.SOF_SEEN(sof), .BIT_TICK(tick), .ERR_COND(err_cond), .CAN_RX(rx),
		.SLEEP_ACK(sleep_ack), .FREEZE_ACK(freeze_ack),
		.STATUS_IRQ(status_irq), .IRQ(irq));
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	task automatic end_sim;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	// write; readiness sampled mid-cycle so it is the value at the edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ao, wo, bo;
		logic [1:0] r;
		int n;
		n = 0;
		bo = 0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!bo && n < 64) begin
			@(negedge mclk);
			ao = awvalid && awready;
			wo = wvalid && wready;
			bo = bvalid;
			r = bresp;
			@(posedge mclk);
			if (ao) awvalid <= 1'b0;
			if (wo) wvalid <= 1'b0;
			n++;
		end
		bready <= 1'b0;
		`CHK("bresp", er, r)
		if (!bo) begin
			num_errors++;
			end_sim();
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic ao, ro;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		n = 0;
		ro = 0;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!ro && n < 64) begin
			@(negedge mclk);
			ao = arvalid && arready;
			ro = rvalid;
			d = rdata;
			r = rresp;
			@(posedge mclk);
			if (ao) arvalid <= 1'b0;
			n++;
		end
		rready <= 1'b0;
		`CHK("rdata", ed, d)
		`CHK("rresp", er, r)
		if (!ro) begin
			num_errors++;
			end_sim();
		end
	endtask : rd
	// bounded wait on an acknowledge level
	task automatic ack_wait(input logic frz, input logic v);
		int n;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while ((frz ? freeze_ack : sleep_ack) !== v && n < 300);
		`CHK("ack", v, frz ? freeze_ack : sleep_ack)
		@(posedge mclk);
	endtask : ack_wait
	task automatic frame(input logic t);
		@(posedge mclk);
		start_tx <= t;
		start_rx <= !t;
		@(posedge mclk);
		start_tx <= 1'b0;
		start_rx <= 1'b0;
	endtask : frame
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		rd(OFS_MASTER_STATUS, 32'h2, RESP_OKAY);
		rd(OFS_CONTROL, 32'h2, RESP_OKAY);
		rd(8'h14, 32'h0, RESP_SLVERR);
		wr(8'h14, 32'hFFFFFFFF, RESP_SLVERR);
		wr(OFS_MASTER_STATUS, 32'hFFFFFFFF, RESP_OKAY);
		rd(OFS_MASTER_STATUS, 32'h2, RESP_OKAY);
		$display("reset test done");
		wr(OFS_IRQ_ENABLE, 32'h3, RESP_OKAY);
		wr(OFS_EVENT_MASK, 32'h7F, RESP_OKAY);
		wr(OFS_CONTROL, 32'h0, RESP_OKAY);
		repeat (20) @(negedge mclk);
		`CHK("early sleep exit", 1'b1, sleep_ack)
		ack_wait(0, 0);
		rd(OFS_MASTER_STATUS, 32'h8, RESP_OKAY);
		@(negedge mclk);
		`CHK("status_irq", 1'b1, status_irq)
		`CHK("irq", 1'b1, irq)
		wr(OFS_MASTER_STATUS, 32'h0, RESP_OKAY);
		rd(OFS_MASTER_STATUS, 32'h8, RESP_OKAY);
		rd(OFS_EVENT_STATUS, 32'h8, RESP_OKAY);
		rd(OFS_EVENT_STATUS, 32'h0, RESP_OKAY);
		@(negedge mclk);
		`CHK("irq", 1'b0, irq)
		wr(OFS_MASTER_STATUS, 32'h8, RESP_OKAY);
		rd(OFS_MASTER_STATUS, 32'h0, RESP_OKAY);
		$display("sleep exit test done");
		frame(1);
		rd(OFS_MASTER_STATUS, 32'h100, RESP_OKAY);
		wr(OFS_CONTROL, 32'h2, RESP_OKAY);
		@(negedge mclk);
		`CHK("sleep during tx", 1'b0, sleep_ack)
		ack_wait(0, 1);
		rd(OFS_MASTER_STATUS, 32'h12, RESP_OKAY);
		@(negedge mclk);
		`CHK("status_irq", 1'b1, status_irq)
		wr(OFS_CONTROL, 32'h0, RESP_OKAY);
		ack_wait(0, 0);
		rd(OFS_MASTER_STATUS, 32'h8, RESP_OKAY);
		wr(OFS_MASTER_STATUS, 32'h8, RESP_OKAY);
		$display("sleep entry test done");
		frame(0);
		wr(OFS_CONTROL, 32'h1, RESP_OKAY);
		@(negedge mclk);
		`CHK("freeze during rx", 1'b0, freeze_ack)
		ack_wait(1, 1);
		rd(OFS_MASTER_STATUS, 32'h1, RESP_OKAY);
		wr(OFS_CONTROL, 32'h0, RESP_OKAY);
		repeat (20) @(negedge mclk);
		`CHK("early freeze exit", 1'b1, freeze_ack)
		ack_wait(1, 0);
		rd(OFS_MASTER_STATUS, 32'h0, RESP_OKAY);
		$display("freeze test done");
		wr(OFS_IRQ_ENABLE, 32'h104, RESP_OKAY);
		@(posedge mclk);
		err_cond <= 4'h2;
		rd(OFS_MASTER_STATUS, 32'h0, RESP_OKAY);
		err_cond <= 4'h1;
		rd(OFS_MASTER_STATUS, 32'h4, RESP_OKAY);
		@(negedge mclk);
		`CHK("status_irq", 1'b1, status_irq)
		@(posedge mclk);
		err_cond <= 4'h0;
		wr(OFS_MASTER_STATUS, 32'h4, RESP_OKAY);
		rd(OFS_MASTER_STATUS, 32'h0, RESP_OKAY);
		@(negedge mclk);
		`CHK("status_irq", 1'b0, status_irq)
		wr(OFS_CONTROL, 32'h8000, RESP_OKAY);
		rd(OFS_CONTROL, 32'h2, RESP_OKAY);
		ack_wait(0, 1);
		$display("error and soft reset test done");
		wr(OFS_CONTROL, 32'h22, RESP_OKAY);
		frame(0);
		rd(OFS_CONTROL, 32'h20, RESP_OKAY);
		rd(OFS_MASTER_STATUS, 32'hA, RESP_OKAY);
		ack_wait(0, 0);
		rd(OFS_MASTER_STATUS, 32'h8, RESP_OKAY);
		$display("start-of-frame wake test done");
		end_sim();
	end
endmodule : can_master_status_flags_tb

// ---- tb/master_status_sva.sv ----
// assertion checker for the master status flag block ports
module master_status_sva
	import master_status_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [DATA_W-1:0] RDATA,
	input wire logic RVALID,
	input wire logic TX_BUSY,
	input wire logic RX_BUSY,
	input wire logic BIT_TICK,
	input wire logic CAN_RX,
	input wire logic SLEEP_ACK,
	input wire logic FREEZE_ACK,
	input wire logic STATUS_IRQ,
	input wire logic IRQ
);
	// ------------------------------------------------------------
	// helper state
	// ------------------------------------------------------------
	logic [3:0] rec_r;
	logic [3:0] rec_nxt;
	logic st_r;
	logic st_nxt;
	// raw pin count leads the synced one, so it is a safe upper bound
	always_comb begin
		rec_nxt = rec_r;
		if (!CAN_RX)
			rec_nxt = 4'h0;
		else if (BIT_TICK && rec_r != 4'hF)
			rec_nxt = rec_r + 4'h1;
		st_nxt = st_r;
		if (ARVALID && ARREADY)
			st_nxt = (ARADDR == OFS_MASTER_STATUS);
	end
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			rec_r <= 4'h0;
			st_r <= 1'b0;
		end else begin
			rec_r <= rec_nxt;
			st_r <= st_nxt;
		end
	end
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	chk_rst_acks: assert property (
		disable iff (1'b0) !RST_N |=> SLEEP_ACK && !FREEZE_ACK && !IRQ)
		else $error("acks or irq wrong after reset");
	chk_sleep_defer: assert property (
		$rose(SLEEP_ACK) |-> !$past(TX_BUSY) && !$past(RX_BUSY))
		else $error("sleep entered while busy");
	chk_frz_defer: assert property (
		$rose(FREEZE_ACK) |-> !$past(TX_BUSY) && !$past(RX_BUSY))
		else $error("freeze entered while busy");
	chk_sleep_exit: assert property (
		$fell(SLEEP_ACK) |-> rec_r >= 4'hB)
		else $error("sleep left too early");
	chk_frz_exit: assert property (
		$fell(FREEZE_ACK) |-> rec_r >= 4'hB)
		else $error("freeze left too early");
	chk_ack_excl: assert property (
		!(SLEEP_ACK && FREEZE_ACK))
		else $error("sleep and freeze both acknowledged");
	chk_read_lat: assert property (
		ARVALID && ARREADY |=> RVALID && !ARREADY)
		else $error("read data late");
	chk_rsv_zero: assert property (
		RVALID && st_r |-> RDATA[7:5] == 3'h0 && RDATA[31:9] == 23'h0)
		else $error("reserved status bits set");
	cover property ($fell(SLEEP_ACK));
	cover property ($rose(FREEZE_ACK));
	cover property ($rose(STATUS_IRQ));
endmodule : master_status_sva

bind can_master_status_flags master_status_sva i_chk (
	.MCLK(MCLK), .RST_N(RST_N), .ARADDR(ARADDR), .ARVALID(ARVALID),
	.ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID),
	.TX_BUSY(TX_BUSY), .RX_BUSY(RX_BUSY), .BIT_TICK(BIT_TICK),
	.CAN_RX(CAN_RX), .SLEEP_ACK(SLEEP_ACK), .FREEZE_ACK(FREEZE_ACK),
	.STATUS_IRQ(STATUS_IRQ), .IRQ(IRQ));

// ---- verilog/can_master_status_flags.sv ----
// master status flags, sleep and freeze acknowledge logic with its bus slave
module can_master_status_flags
	import master_status_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST_N,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	// axi4-lite write data
	input wire logic [DATA_W-1:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	// axi4-lite write response
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	// axi4-lite read data
	output logic [DATA_W-1:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// controller core, same clock
	input wire logic TX_BUSY,
	input wire logic RX_BUSY,
	input wire logic SOF_SEEN,
	input wire logic BIT_TICK,
	input wire logic [ERR_W-1:0] ERR_COND,
	// receive pin, asynchronous
	input wire logic CAN_RX,
	// mode and interrupt outputs
	output logic SLEEP_ACK,
	output logic FREEZE_ACK,
	output logic STATUS_IRQ,
	output logic IRQ
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		mode_t mode;
		logic [3:0] rec_cnt;
		logic rx_meta;
		logic rx_sync;
		logic tx_active;
		logic sleep_ack;
		logic freeze_ack;
		logic sleep_request;
		logic freeze_request;
		logic auto_wake;
		logic sleep_entry_irq_enable;
		logic sleep_exit_irq_enable;
		logic error_irq_enable;
		logic [ERR_W-1:0] err_src_en;
		logic sleep_entry_flag;
		logic sleep_exit_flag;
		logic error_event_flag;
		logic [EVT_W-1:0] evt;
		logic [EVT_W-1:0] evt_mask;
		logic awready;
		logic wready;
		logic aw_held;
		logic w_held;
		logic [ADDR_W-1:0] waddr;
		logic [DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
		logic status_irq;
		logic irq;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	// combinational helpers, all driven by the single comb process
	logic [DATA_W-1:0] wmask;
	logic [DATA_W-1:0] w1c;
	logic wake_cond;
	logic sleep_in;
	logic sleep_out;
	logic [EVT_W-1:0] evt_set;
	logic [EVT_W-1:0] evt_clr;
	logic [DATA_W-1:0] rd_word;
	logic rd_hit;

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		wmask = '0;
		w1c = '0;
		wake_cond = 1'b0;
		sleep_in = 1'b0;
		sleep_out = 1'b0;
		evt_set = '0;
		evt_clr = '0;
		rd_word = '0;
		rd_hit = 1'b1;

		// pin synchroniser: the first stage feeds only the second
		s_nxt.rx_meta = CAN_RX;
		s_nxt.rx_sync = s_r.rx_meta;

		s_nxt.tx_active = TX_BUSY;

		// write channels are taken independently, in either order
		if (AWVALID && s_r.awready) begin
			s_nxt.aw_held = 1'b1;
			s_nxt.waddr = AWADDR;
		end
		if (WVALID && s_r.wready) begin
			s_nxt.w_held = 1'b1;
			s_nxt.wdata = WDATA;
			s_nxt.wstrb = WSTRB;
		end
		if (s_r.bvalid && BREADY) begin
			s_nxt.bvalid = 1'b0;
		end

		// a write completes once both halves are held and b is free
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{s_r.wstrb[i]}};
		end
		if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
			s_nxt.aw_held = 1'b0;
			s_nxt.w_held = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = RESP_OKAY;
			unique case (s_r.waddr)
				OFS_MASTER_STATUS: begin
					// only flags react; zeros and ro bits ignored
					w1c = s_r.wdata & wmask;
				end
				OFS_CONTROL: begin
					if (wmask[CT_FREEZE_REQUEST]) begin
						s_nxt.freeze_request = s_r.wdata[CT_FREEZE_REQUEST];
					end
					if (wmask[CT_SLEEP_REQUEST]) begin
						s_nxt.sleep_request = s_r.wdata[CT_SLEEP_REQUEST];
					end
					if (wmask[CT_AUTO_WAKE]) begin
						s_nxt.auto_wake = s_r.wdata[CT_AUTO_WAKE];
					end
					if (wmask[CT_SOFT_RESET] && s_r.wdata[CT_SOFT_RESET]) begin
						s_nxt.sleep_request = 1'b1;
						s_nxt.freeze_request = 1'b0;
					end
				end
				OFS_IRQ_ENABLE: begin
					if (wmask[IE_SLEEP_ENTRY]) begin
						s_nxt.sleep_entry_irq_enable = s_r.wdata[IE_SLEEP_ENTRY];
					end
					if (wmask[IE_SLEEP_EXIT]) begin
						s_nxt.sleep_exit_irq_enable = s_r.wdata[IE_SLEEP_EXIT];
					end
					if (wmask[IE_ERROR]) begin
						s_nxt.error_irq_enable = s_r.wdata[IE_ERROR];
					end
					if (wmask[IE_ERR_SRC_LSB]) begin
						s_nxt.err_src_en =
							s_r.wdata[IE_ERR_SRC_LSB +: ERR_W];
					end
				end
				OFS_EVENT_STATUS: begin
					// read-only; a write is accepted and ignored
				end
				OFS_EVENT_MASK: begin
					if (wmask[0]) begin
						s_nxt.evt_mask = s_r.wdata[EVT_W-1:0];
					end
				end
				default: begin
					s_nxt.bresp = RESP_SLVERR;
				end
			endcase
		end
		s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_held && !s_nxt.bvalid;

		// recessive bit counter, live only while leaving a mode
		if (s_r.mode == MODE_SLEEP_EXIT || s_r.mode == MODE_FREEZE_EXIT) begin
			if (BIT_TICK) begin
				if (!s_r.rx_sync) begin
					s_nxt.rec_cnt = '0;
				end else if (s_r.rec_cnt != RECESSIVE_BITS) begin
					s_nxt.rec_cnt = s_r.rec_cnt + 4'h1;
				end
			end
		end else begin
			s_nxt.rec_cnt = '0;
		end

		// mode sequencing; hardware decisions follow software writes
		unique case (s_r.mode)
			MODE_NORMAL: begin
				// sleep deferred while the bus is busy
				if (s_r.sleep_request && !(TX_BUSY || RX_BUSY)) begin
					s_nxt.mode = MODE_SLEEP;
				// freeze deferred while the bus is busy
				end else if (s_r.freeze_request && !(TX_BUSY || RX_BUSY)) begin
					s_nxt.mode = MODE_FREEZE;
				end
			end
			MODE_SLEEP: begin
				if (s_r.auto_wake && SOF_SEEN) begin
					wake_cond = 1'b1;
					s_nxt.sleep_request = 1'b0;
					s_nxt.mode = MODE_SLEEP_EXIT;
				end else if (!s_r.sleep_request) begin
					s_nxt.mode = MODE_SLEEP_EXIT;
				end
			end
			MODE_SLEEP_EXIT: begin
				if (s_r.sleep_request) begin
					s_nxt.mode = MODE_SLEEP;
				end else if (s_r.rec_cnt == RECESSIVE_BITS) begin
					s_nxt.mode = MODE_NORMAL;
				end
			end
			MODE_FREEZE: begin
				if (!s_r.freeze_request) begin
					s_nxt.mode = MODE_FREEZE_EXIT;
				end
			end
			MODE_FREEZE_EXIT: begin
				if (s_r.freeze_request) begin
					s_nxt.mode = MODE_FREEZE;
				end else if (s_r.rec_cnt == RECESSIVE_BITS) begin
					s_nxt.mode = MODE_NORMAL;
				end
			end
			default: begin
				s_nxt.mode = MODE_NORMAL;
			end
		endcase

		s_nxt.sleep_ack = (s_nxt.mode == MODE_SLEEP)
			|| (s_nxt.mode == MODE_SLEEP_EXIT);
		s_nxt.freeze_ack = (s_nxt.mode == MODE_FREEZE)
			|| (s_nxt.mode == MODE_FREEZE_EXIT);
		sleep_in = !s_r.sleep_ack && s_nxt.sleep_ack;
		sleep_out = s_r.sleep_ack && !s_nxt.sleep_ack;

		// entry flag: set wins over the written clear
		s_nxt.sleep_entry_flag = (s_r.sleep_entry_flag
			&& !w1c[MS_SLEEP_ENTRY_FLAG] && !sleep_out)
			|| (s_r.sleep_entry_irq_enable && sleep_in);

		// exit flag: only a written one clears it
		s_nxt.sleep_exit_flag = (s_r.sleep_exit_flag
			&& !w1c[MS_SLEEP_EXIT_FLAG]) || sleep_out || wake_cond;

		// error flag from enabled error conditions
		s_nxt.error_event_flag = (s_r.error_event_flag
			&& !w1c[MS_ERROR_EVENT_FLAG])
			|| (|(ERR_COND & s_r.err_src_en));

		s_nxt.status_irq = s_nxt.sleep_entry_flag
			|| (s_nxt.sleep_exit_flag && s_nxt.sleep_exit_irq_enable)
			|| (s_nxt.error_event_flag && s_nxt.error_irq_enable);

		// read channel; an accepted read returns next cycle
		if (s_r.rvalid && RREADY) begin
			s_nxt.rvalid = 1'b0;
		end
		unique case (ARADDR)
			OFS_MASTER_STATUS: begin
				// bits 7 to 5 stay zero
				rd_word[MS_TRANSMIT_ACTIVE] = s_r.tx_active;
				rd_word[MS_SLEEP_ENTRY_FLAG] = s_r.sleep_entry_flag;
				rd_word[MS_SLEEP_EXIT_FLAG] = s_r.sleep_exit_flag;
				rd_word[MS_ERROR_EVENT_FLAG] = s_r.error_event_flag;
				rd_word[MS_SLEEP_ACK] = s_r.sleep_ack;
				rd_word[MS_FREEZE_ACK] = s_r.freeze_ack;
			end
			OFS_CONTROL: begin
				rd_word[CT_FREEZE_REQUEST] = s_r.freeze_request;
				rd_word[CT_SLEEP_REQUEST] = s_r.sleep_request;
				rd_word[CT_AUTO_WAKE] = s_r.auto_wake;
			end
			OFS_IRQ_ENABLE: begin
				rd_word[IE_SLEEP_ENTRY] = s_r.sleep_entry_irq_enable;
				rd_word[IE_SLEEP_EXIT] = s_r.sleep_exit_irq_enable;
				rd_word[IE_ERROR] = s_r.error_irq_enable;
				rd_word[IE_ERR_SRC_LSB +: ERR_W] = s_r.err_src_en;
			end
			OFS_EVENT_STATUS: begin
				rd_word[EVT_W-1:0] = s_r.evt;
			end
			OFS_EVENT_MASK: begin
				rd_word[EVT_W-1:0] = s_r.evt_mask;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
		if (ARVALID && s_r.arready) begin
			s_nxt.arready = 1'b0;
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = rd_word;
			s_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
			if (ARADDR == OFS_EVENT_STATUS) begin
				evt_clr = '1;
			end
		end else if (!s_nxt.rvalid) begin
			s_nxt.arready = 1'b1;
		end

		// sticky events; a new event beats the clearing read
		evt_set[EV_TX_START] = TX_BUSY && !s_r.tx_active;
		evt_set[EV_TX_END] = !TX_BUSY && s_r.tx_active;
		evt_set[EV_SLEEP_IN] = sleep_in;
		evt_set[EV_SLEEP_OUT] = sleep_out;
		evt_set[EV_FREEZE_IN] = !s_r.freeze_ack && s_nxt.freeze_ack;
		evt_set[EV_FREEZE_OUT] = s_r.freeze_ack && !s_nxt.freeze_ack;
		evt_set[EV_ERROR] = |(ERR_COND & s_r.err_src_en);
		s_nxt.evt = (s_r.evt & ~evt_clr) | evt_set;
		s_nxt.irq = |(s_nxt.evt & s_nxt.evt_mask);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	// synchronous reset; start in sleep with the request set
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			s_r <= '0;
			s_r.mode <= MODE_SLEEP;
			s_r.sleep_ack <= RST_SLEEP_ACK;
			s_r.freeze_ack <= RST_FREEZE_ACK;
			s_r.sleep_request <= RST_SLEEP_REQUEST;
			s_r.evt_mask <= RST_EVENT_MASK;
			s_r.rx_meta <= 1'b1;
			s_r.rx_sync <= 1'b1;
			s_r.awready <= 1'b1;
			s_r.wready <= 1'b1;
			s_r.arready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs, each straight from the state register
	// ------------------------------------------------------------
	assign AWREADY = s_r.awready;
	assign WREADY = s_r.wready;
	assign BRESP = s_r.bresp;
	assign BVALID = s_r.bvalid;
	assign ARREADY = s_r.arready;
	assign RDATA = s_r.rdata;
	assign RRESP = s_r.rresp;
	assign RVALID = s_r.rvalid;
	assign SLEEP_ACK = s_r.sleep_ack;
	assign FREEZE_ACK = s_r.freeze_ack;
	assign STATUS_IRQ = s_r.status_irq;
	assign IRQ = s_r.irq;
endmodule : can_master_status_flags

// ---- verilog/master_status_pkg.sv ----
// constants, field layout and types for the master status flag block
package master_status_pkg;

	// ------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int ERR_W = 4;
	localparam int EVT_W = 7;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_MASTER_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_EVENT_MASK = 8'h10;

	// ------------------------------------------------------------
	// master status register fields
	// ------------------------------------------------------------
	localparam int MS_TRANSMIT_ACTIVE = 8;
	localparam int MS_SLEEP_ENTRY_FLAG = 4;
	localparam int MS_SLEEP_EXIT_FLAG = 3;
	localparam int MS_ERROR_EVENT_FLAG = 2;
	localparam int MS_SLEEP_ACK = 1;
	localparam int MS_FREEZE_ACK = 0;

	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int CT_FREEZE_REQUEST = 0;
	localparam int CT_SLEEP_REQUEST = 1;
	localparam int CT_AUTO_WAKE = 5;
	localparam int CT_SOFT_RESET = 15;

	// ------------------------------------------------------------
	// interrupt enable register fields
	// ------------------------------------------------------------
	localparam int IE_SLEEP_ENTRY = 0;
	localparam int IE_SLEEP_EXIT = 1;
	localparam int IE_ERROR = 2;
	localparam int IE_ERR_SRC_LSB = 8;

	// ------------------------------------------------------------
	// event status bits (read clears)
	// ------------------------------------------------------------
	localparam int EV_TX_START = 0;
	localparam int EV_TX_END = 1;
	localparam int EV_SLEEP_IN = 2;
	localparam int EV_SLEEP_OUT = 3;
	localparam int EV_FREEZE_IN = 4;
	localparam int EV_FREEZE_OUT = 5;
	localparam int EV_ERROR = 6;

	// ------------------------------------------------------------
	// reset values, responses, timing
	// ------------------------------------------------------------
	localparam logic RST_SLEEP_REQUEST = 1'b1;
	localparam logic RST_SLEEP_ACK = 1'b1;
	localparam logic RST_FREEZE_ACK = 1'b0;
	localparam logic [EVT_W-1:0] RST_EVENT_MASK = 7'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [3:0] RECESSIVE_BITS = 4'hB;

	typedef enum logic [2:0] {
		MODE_NORMAL,
		MODE_SLEEP,
		MODE_SLEEP_EXIT,
		MODE_FREEZE,
		MODE_FREEZE_EXIT
	} mode_t;

endpackage : master_status_pkg
